//--- rtl/blso_pkg.sv
`default_nettype none
package blso_pkg;
    // Security register field positions
    localparam int SEC_JTAG_OFF = 0;
    localparam int SEC_LINK_OFF = 1;
    localparam int SEC_SECURE_BOOT = 5;
    localparam int SEC_REDUNDANT = 7;
    localparam int SEC_SECTOR_LOCK_LO = 8;
    localparam int SEC_MASTER_LOCK = 12;
    localparam int SEC_JTAG_OTP_OFF = 13;
    localparam int SEC_GP_LO = 15;
    localparam int SEC_GP_HI = 21;
    localparam int SEC_UID_LO = 22;
    localparam int SEC_UID_HI = 31;
    // One-time memory geometry
    localparam int OTP_SECTORS = 4;
    localparam int OTP_ROWS = 512;
    localparam int OTP_WORDS = OTP_SECTORS * OTP_ROWS;
    localparam int OTP_AW = 11;
    localparam logic [10:0] OTP_SEC_ROW = 11'h7ff;
    // Programming port resource identifiers
    localparam logic [23:0] RES_OTP_ADDR = 24'h100200;
    localparam logic [23:0] RES_OTP_DATA = 24'h200100;
    localparam logic [23:0] RES_OTP_CTRL = 24'h100300;
    // Register offsets
    localparam logic [3:0] REG_SECURITY = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_OTP_ADDR = 4'h2;
    localparam logic [3:0] REG_OTP_DATA = 4'h3;
    localparam logic [3:0] REG_OTP_CTRL = 4'h4;
    localparam logic [3:0] REG_CRC = 4'h5;
    localparam logic [15:0] CTRL_PROGRAM = 16'h0001;
    // CRC
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [31:0] CRC_SKIP = 32'h0d15ab1e;
    // Timing
    localparam int CLK_HZ = 50000000;
    localparam int BOOT_DELAY_US = 15;
    localparam int BOOT_DELAY_CYC = (BOOT_DELAY_US * (CLK_HZ / 1000000));
    localparam int RAM_AW = 16;
endpackage : blso_pkg
`default_nettype wire

//--- rtl/blso_crc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface blso_crc_if;
    logic clear;
    logic valid;
    logic [7:0] data;
    logic [31:0] crc;
    modport master (output clear, output valid, output data, input crc);
    modport engine (input clear, input valid, input data, output crc);
endinterface : blso_crc_if
`default_nettype wire

//--- rtl/blso_crc32.sv
`timescale 1ns/1ps
`default_nettype none
module blso_crc32 (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Byte stream
    blso_crc_if.engine cif
);
    logic [31:0] res_q, res_d;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h000000, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ blso_pkg::CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_byte

    always_comb begin
        res_d = res_q;
        if (cif.clear) begin
            res_d = blso_pkg::CRC_INIT;
        end else if (cif.valid) begin
            res_d = crc_byte(res_q, cif.data);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            res_q <= 32'hffffffff;
        end else begin
            res_q <= res_d;
        end
    end

    // Residue is inverted to give the CRC value
    assign cif.crc = ~res_q;
endmodule : blso_crc32
`default_nettype wire

//--- rtl/blso_boot_loader.sv
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module blso_boot_loader #(
    parameter int BOOT_DELAY = blso_pkg::BOOT_DELAY_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Pins
    output logic gpio_pulldown_en,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Flash byte source
    output logic flash_req,
    output logic [23:0] flash_addr,
    input wire logic flash_valid,
    input wire logic [7:0] flash_data,
    // RAM write port
    output logic ram_we,
    output logic [15:0] ram_addr,
    output logic [7:0] ram_wdata,
    // Processor start
    output logic cpu_start,
    output logic [15:0] cpu_start_addr,
    output logic boot_failed,
    // Access gates
    output logic jtag_tile_allow,
    output logic link_access_allow,
    output logic jtag_otp_allow,
    output logic otp_redundant_en,
    output logic [31:0] jtag_usercode
);
    // ==========================================
    // Declarations
    typedef enum logic [8:0] {
        ST_POR     = 9'h001,
        ST_SECLOAD = 9'h002,
        ST_DELAY   = 9'h004,
        ST_COUNT   = 9'h008,
        ST_PROG    = 9'h010,
        ST_CRC     = 9'h020,
        ST_CHECK   = 9'h040,
        ST_RUN     = 9'h080,
        ST_FAIL    = 9'h100
    } blso_state_type;

    logic [31:0] otp_mem [blso_pkg::OTP_WORDS];
    blso_state_type st_q, st_d;
    logic [31:0] sec_q, sec_d;
    logic [15:0] cnt_q, cnt_d;
    logic [31:0] word_q, word_d;
    logic [1:0] bidx_q, bidx_d;
    logic [31:0] left_q, left_d;
    logic [15:0] ram_ptr_q, ram_ptr_d;
    logic [23:0] src_q, src_d;
    logic otp_src_q, otp_src_d;
    logic [31:0] otp_word_q;
    logic [15:0] pa_q, pa_d, pc_q;
    logic [31:0] pd_q, pd_d;
    logic [15:0] pc_d;
    logic [31:0] crc_got_q, crc_got_d;
    logic prog_ok;
    logic byte_ok;
    logic [7:0] byte_in;
    logic [31:0] word_nx;
    blso_crc_if crc_bus ();

    blso_crc32 u_crc (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .cif(crc_bus)
    );

    function automatic logic prog_allowed(input logic [31:0] sec, input logic [15:0] a);
        logic ok;
        ok = !sec[blso_pkg::SEC_MASTER_LOCK];
        if (a[10:0] == blso_pkg::OTP_SEC_ROW) begin
            prog_allowed = ok;
        end else begin
            prog_allowed = ok && !sec[blso_pkg::SEC_SECTOR_LOCK_LO + int'(a[10:9])];
        end
    endfunction : prog_allowed

    // ==========================================
    // Byte source: flash or one-time memory
    // Unprogrammed rows read as zero; contents survive every reset, so no reset branch
    initial begin
        for (int i = 0; i < blso_pkg::OTP_WORDS; i++) begin
            otp_mem[i] = 32'h00000000;
        end
    end

    // Reading the memory is registered so the byte lane lags the request by one cycle
    always_ff @(posedge sys_clk) begin
        otp_word_q <= otp_mem[src_q[12:2]];
    end

    assign byte_in = otp_src_q ? otp_word_q[8 * src_q[1:0] +: 8] : flash_data;
    assign byte_ok = otp_src_q ? (st_q == ST_COUNT || st_q == ST_PROG || st_q == ST_CRC) && cnt_q[0] : flash_valid;
    assign word_nx = {byte_in, word_q[31:8]};
    assign flash_req = !otp_src_q && (st_q == ST_COUNT || st_q == ST_PROG || st_q == ST_CRC);
    assign flash_addr = src_q;
    assign prog_ok = prog_allowed(sec_q, pa_q);

    // ==========================================
    // Boot sequencer
    always_comb begin
        st_d = st_q;
        sec_d = sec_q;
        cnt_d = cnt_q;
        word_d = word_q;
        bidx_d = bidx_q;
        left_d = left_q;
        ram_ptr_d = ram_ptr_q;
        src_d = src_q;
        otp_src_d = otp_src_q;
        crc_got_d = crc_got_q;
        crc_bus.clear = 1'b0;
        crc_bus.valid = 1'b0;
        crc_bus.data = byte_in;
        ram_we = 1'b0;
        case (st_q)
            ST_POR: begin
                src_d = 24'h000000;
                st_d = ST_SECLOAD;
            end
            ST_SECLOAD: begin
                // Security word kept in the last row; one cycle for the read
                src_d = {11'h000, blso_pkg::OTP_SEC_ROW, 2'b00};
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q == 16'h0002) begin
                    sec_d = otp_word_q;
                    cnt_d = 16'h0000;
                    st_d = ST_DELAY;
                end
            end
            ST_DELAY: begin
                cnt_d = cnt_q + 16'h0001;
                src_d = 24'h000000;
                if (cnt_q == 16'(BOOT_DELAY - 1)) begin
                    otp_src_d = sec_q[blso_pkg::SEC_SECURE_BOOT];
                    crc_bus.clear = 1'b1;
                    cnt_d = 16'h0000;
                    bidx_d = 2'd0;
                    ram_ptr_d = 16'h0000;
                    st_d = ST_COUNT;
                end
            end
            ST_COUNT, ST_PROG, ST_CRC: begin
                if (otp_src_q) begin
                    cnt_d = {15'h0000, ~cnt_q[0]};
                end
                if (byte_ok) begin
                    src_d = src_q + 24'h000001;
                    bidx_d = bidx_q + 2'd1;
                    word_d = word_nx;
                    crc_bus.valid = (st_q != ST_CRC);
                    if (st_q == ST_PROG) begin
                        ram_we = 1'b1;
                        ram_ptr_d = ram_ptr_q + 16'h0001;
                    end
                    if (bidx_q == 2'd3) begin
                        case (st_q)
                            ST_COUNT: begin
                                left_d = word_nx;
                                st_d = (word_nx == 32'h0) ? ST_CRC : ST_PROG;
                            end
                            ST_PROG: begin
                                left_d = left_q - 32'h1;
                                st_d = (left_q == 32'h1) ? ST_CRC : ST_PROG;
                            end
                            default: begin
                                crc_got_d = word_nx;
                                st_d = ST_CHECK;
                            end
                        endcase
                    end
                end
            end
            ST_CHECK: begin
                if (crc_got_q == blso_pkg::CRC_SKIP || crc_got_q == crc_bus.crc) begin
                    st_d = ST_RUN;
                end else begin
                    st_d = ST_FAIL;
                end
            end
            ST_RUN: st_d = ST_RUN;
            ST_FAIL: st_d = ST_FAIL;
            default: st_d = ST_POR;
        endcase
        // Security register can be reprogrammed unless master lock is set
        if (reg_wr && reg_addr == blso_pkg::REG_OTP_CTRL && (reg_wdata[15:0] & blso_pkg::CTRL_PROGRAM) != 16'h0
            && prog_ok && pa_q[10:0] == blso_pkg::OTP_SEC_ROW) begin
            // Builds on sec_d so a program in the load cycle does not drop the loaded word
            sec_d = sec_d | pd_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= ST_POR;
            sec_q <= 32'h00000000;
            cnt_q <= 16'h0000;
            word_q <= 32'h00000000;
            bidx_q <= 2'd0;
            left_q <= 32'h00000000;
            ram_ptr_q <= 16'h0000;
            src_q <= 24'h000000;
            otp_src_q <= 1'b0;
            crc_got_q <= 32'h00000000;
        end else begin
            st_q <= st_d;
            sec_q <= sec_d;
            cnt_q <= cnt_d;
            word_q <= word_d;
            bidx_q <= bidx_d;
            left_q <= left_d;
            ram_ptr_q <= ram_ptr_d;
            src_q <= src_d;
            otp_src_q <= otp_src_d;
            crc_got_q <= crc_got_d;
        end
    end

    // ==========================================
    // Programming ports and register reads
    always_comb begin
        pa_d = pa_q;
        pd_d = pd_q;
        pc_d = pc_q;
        if (reg_wr) begin
            case (reg_addr)
                blso_pkg::REG_OTP_ADDR: pa_d = reg_wdata[15:0];
                blso_pkg::REG_OTP_DATA: pd_d = reg_wdata;
                blso_pkg::REG_OTP_CTRL: pc_d = reg_wdata[15:0];
                default: pa_d = pa_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pa_q <= 16'h0000;
            pd_q <= 32'h00000000;
            pc_q <= 16'h0000;
            reg_rdata <= 32'h00000000;
        end else begin
            pa_q <= pa_d;
            pd_q <= pd_d;
            pc_q <= pc_d;
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                case (reg_addr)
                    blso_pkg::REG_SECURITY: reg_rdata <= sec_q;
                    blso_pkg::REG_STATUS: reg_rdata <= {23'h0, st_q};
                    blso_pkg::REG_OTP_ADDR: reg_rdata <= {16'h0, pa_q};
                    blso_pkg::REG_OTP_DATA: reg_rdata <= pd_q;
                    blso_pkg::REG_OTP_CTRL: reg_rdata <= {16'h0, pc_q};
                    blso_pkg::REG_CRC: reg_rdata <= crc_got_q;
                    default: reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    // One-time memory bits only ever go from zero to one
    always @(posedge sys_clk) begin
        if (reg_wr && reg_addr == blso_pkg::REG_OTP_CTRL && (reg_wdata[15:0] & blso_pkg::CTRL_PROGRAM) != 16'h0
            && prog_ok) begin
            otp_mem[pa_q[10:0]] <= otp_mem[pa_q[10:0]] | pd_q;
        end
    end

    // ==========================================
    // Outputs
    assign gpio_pulldown_en = (st_q == ST_POR) || (st_q == ST_SECLOAD);
    assign ram_addr = ram_ptr_q;
    assign ram_wdata = byte_in;
    assign cpu_start = (st_q == ST_RUN);
    assign cpu_start_addr = 16'h0000;
    assign boot_failed = (st_q == ST_FAIL);
    assign jtag_tile_allow = !sec_q[blso_pkg::SEC_JTAG_OFF];
    assign link_access_allow = !sec_q[blso_pkg::SEC_LINK_OFF];
    assign jtag_otp_allow = !sec_q[blso_pkg::SEC_JTAG_OTP_OFF];
    assign otp_redundant_en = sec_q[blso_pkg::SEC_REDUNDANT];
    assign jtag_usercode = {sec_q[blso_pkg::SEC_UID_HI:blso_pkg::SEC_UID_LO], 22'h000000};

    // ==========================================
    // Checks
    sequence s_check_bad;
        st_q == ST_CHECK && crc_got_q != blso_pkg::CRC_SKIP && crc_got_q != crc_bus.crc;
    endsequence
    chk_bad_crc_fail: assert property (@(posedge sys_clk) disable iff (!rstn) s_check_bad |=> st_q == ST_FAIL)
        else $error("bad crc did not fail");
    chk_skip_crc_run: assert property (@(posedge sys_clk) disable iff (!rstn)
        st_q == ST_CHECK && crc_got_q == blso_pkg::CRC_SKIP |=> st_q == ST_RUN)
        else $error("skip value did not start");
    chk_jtag_block: assert property (@(posedge sys_clk) disable iff (!rstn)
        sec_q[blso_pkg::SEC_JTAG_OFF] |-> !jtag_tile_allow)
        else $error("jtag not blocked");
    chk_link_block: assert property (@(posedge sys_clk) disable iff (!rstn)
        sec_q[blso_pkg::SEC_LINK_OFF] |-> !link_access_allow)
        else $error("link not blocked");
    chk_jtag_otp_deny: assert property (@(posedge sys_clk) disable iff (!rstn)
        sec_q[blso_pkg::SEC_JTAG_OTP_OFF] |-> !jtag_otp_allow)
        else $error("jtag otp not denied");
    chk_master_lock: assert property (@(posedge sys_clk) disable iff (!rstn)
        sec_q[blso_pkg::SEC_MASTER_LOCK] && st_q == ST_RUN |=> $stable(sec_q))
        else $error("security changed under lock");
    chk_start_addr: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(cpu_start) |-> cpu_start_addr == 16'h0000 && $past(st_q) == ST_CHECK)
        else $error("start not from check");
    chk_boot_delay: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(st_q == ST_DELAY) |-> (st_q == ST_DELAY) [*8])
        else $error("boot started early");
    chk_usercode: assert property (@(posedge sys_clk) disable iff (!rstn)
        jtag_usercode[31:22] == sec_q[31:22] && jtag_usercode[21:0] == 22'h0)
        else $error("usercode mismatch");
endmodule : blso_boot_loader
`default_nettype wire

//--- tb/blso_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Embedded flash byte source
// ==========================================================
module blso_flash_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Byte request side
    input wire logic flash_req,
    input wire logic [23:0] flash_addr,
    output logic flash_valid,
    output logic [7:0] flash_data,
    // Idle cycles between bytes beyond the minimum one, to model a slow part
    input wire logic [3:0] gap
);
    logic [7:0] mem [0:63];
    logic [3:0] wait_q;

    // Bytes come strictly from the requested address, so a loader that skips or
    // repeats an address reads the wrong byte. Between bytes the data toggles,
    // so a stale sample never looks right.
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wait_q <= 4'h0;
            flash_valid <= 1'b0;
            flash_data <= 8'ha5;
        end else if (flash_valid) begin
            flash_valid <= 1'b0;
            flash_data <= ~flash_data;
            wait_q <= 4'h0;
        end else if (flash_req && wait_q >= gap) begin
            flash_valid <= 1'b1;
            flash_data <= mem[flash_addr[5:0]];
        end else begin
            wait_q <= wait_q + 4'h1;
            flash_data <= ~flash_data;
        end
    end
endmodule : blso_flash_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int BD = 10;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] gap = 4'h0;
    logic gpio_pulldown_en, flash_req, flash_valid, ram_we, cpu_start, boot_failed;
    logic jtag_tile_allow, link_access_allow, jtag_otp_allow, otp_redundant_en;
    logic [31:0] reg_rdata, jtag_usercode;
    logic [23:0] flash_addr;
    logic [7:0] flash_data, ram_wdata;
    logic [15:0] ram_addr, cpu_start_addr;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [23:0] exp_faddr = 24'h0;
    logic [15:0] ram_n = 16'h0;
    logic [7:0] img [0:63];

    always #10 sys_clk = ~sys_clk;

    blso_boot_loader #(.BOOT_DELAY(BD)) u_blso_boot_loader (
        .sys_clk(sys_clk), .rstn(rstn), .gpio_pulldown_en(gpio_pulldown_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .flash_req(flash_req), .flash_addr(flash_addr),
        .flash_valid(flash_valid), .flash_data(flash_data), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata), .cpu_start(cpu_start),
        .cpu_start_addr(cpu_start_addr), .boot_failed(boot_failed),
        .jtag_tile_allow(jtag_tile_allow), .link_access_allow(link_access_allow),
        .jtag_otp_allow(jtag_otp_allow), .otp_redundant_en(otp_redundant_en),
        .jtag_usercode(jtag_usercode)
    );

    blso_flash_model u_blso_flash_model (
        .sys_clk(sys_clk), .rstn(rstn), .flash_req(flash_req), .flash_addr(flash_addr),
        .flash_valid(flash_valid), .flash_data(flash_data), .gap(gap)
    );

    // ==========================================================
    // Checking and closing
    // ==========================================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic give_verdict();
        if (err_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // Generous ceiling: all boots together need well under a tenth of it
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    // Fetch order and RAM placement are checked byte by byte as they happen
    always @(posedge sys_clk) begin
        if (flash_valid && flash_req) begin
            chk(flash_addr, exp_faddr);
            exp_faddr++;
        end
        if (ram_we) begin
            chk(ram_addr, ram_n);
            chk(ram_wdata, img[ram_n + 16'h4]);
            ram_n++;
        end
    end

    function automatic logic [31:0] crc_of(input int n);
        logic [31:0] c;
        c = 32'hffffffff;
        for (int i = 0; i < n; i++) begin
            c = c ^ {24'h0, img[i]};
            for (int b = 0; b < 8; b++) begin
                c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
            end
        end
        return ~c;
    endfunction : crc_of

    // ==========================================================
    // Bus and reset tasks
    // ==========================================================
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask : reg_read

    task automatic otp_prog(input logic [10:0] a, input logic [31:0] d);
        reg_write(4'h2, {21'h0, a});
        reg_write(4'h3, d);
        reg_write(4'h4, 32'h00000001);
    endtask : otp_prog

    // Programming takes an unstated time, so poll with a bound
    task automatic poll_sec(input logic [31:0] exp);
        logic [31:0] d;
        reg_read(4'h0, d);
        for (int k = 0; k < 40 && d !== exp; k++) begin
            reg_read(4'h0, d);
        end
        chk(d, exp);
    endtask : poll_sec

    task automatic restart();
        @(posedge sys_clk);
        rstn <= 1'b0;
        exp_faddr = 24'h0;
        ram_n = 16'h0;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(gpio_pulldown_en, 32'h1);
        chk({cpu_start, flash_req, ram_we}, 32'h0);
        @(posedge sys_clk);
        rstn <= 1'b1;
    endtask : restart

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic boot(input int words, input logic [31:0] xr, input logic skip, input logic ok);
        int n;
        int k;
        logic [31:0] crc;
        n = 4 + words * 4;
        for (int i = 0; i < 4; i++) img[i] = 8'(words >> (8 * i));
        for (int i = 4; i < n; i++) img[i] = 8'(i * 29 + 90);
        crc = skip ? 32'h0d15ab1e : (crc_of(n) ^ xr);
        for (int i = 0; i < 4; i++) img[n + i] = crc[8 * i +: 8];
        for (int i = 0; i < 64; i++) u_blso_flash_model.mem[i] = img[i];
        restart();
        k = 0;
        while (flash_req !== 1'b1 && k < BD + 40) begin
            @(negedge sys_clk);
            k++;
        end
        chk(k >= BD && k <= BD + 20, 32'h1);
        k = 0;
        while (cpu_start !== 1'b1 && boot_failed !== 1'b1 && k < 3000) begin
            @(negedge sys_clk);
            k++;
        end
        repeat (2) @(negedge sys_clk);
        chk(cpu_start, ok);
        chk(boot_failed, !ok);
        chk(cpu_start_addr, 32'h0);
        chk(ram_n, words * 4);
        chk(exp_faddr, n + 4);
        chk(gpio_pulldown_en, 32'h0);
    endtask : boot

    task automatic security();
        logic [31:0] v;
        logic [31:0] d;
        v = 32'ha9600000 | 32'h002a8000 | 32'h00002083;
        restart();
        // Let the background flash boot finish before img is reused below
        repeat (150) @(posedge sys_clk);
        chk({jtag_tile_allow, link_access_allow, jtag_otp_allow}, 32'h7);
        otp_prog(11'h7ff, v);
        poll_sec(v);
        chk(jtag_tile_allow, 32'h0);
        chk(link_access_allow, 32'h0);
        chk(jtag_otp_allow, 32'h0);
        chk(otp_redundant_en, 32'h1);
        chk(jtag_usercode, {v[31:22], 22'h0});
        reg_read(4'h0, d);
        chk(d[21:15], 32'h55);
        reg_write(4'hf, 32'hffffffff);
        // Sector 1 locked after one row lands; sector 0 still takes the count word
        otp_prog(11'h200, 32'h00000001);
        otp_prog(11'h7ff, 32'h00000200);
        otp_prog(11'h201, 32'h00000001);
        otp_prog(11'h000, 32'h00000001);
        @(negedge sys_clk);
        chk(u_blso_boot_loader.otp_mem[11'h200], 32'h1);
        chk(u_blso_boot_loader.otp_mem[11'h201], 32'h0);
        chk(u_blso_boot_loader.otp_mem[11'h000], 32'h1);
        // Secure boot: one-word image with the skip value, read from the memory
        otp_prog(11'h001, 32'h44332211);
        otp_prog(11'h002, 32'h0d15ab1e);
        otp_prog(11'h7ff, 32'h00000020);
        for (int i = 4; i < 8; i++) img[i] = 8'(17 * (i - 3));
        restart();
        repeat (60) @(negedge sys_clk);
        chk(cpu_start, 32'h1);
        chk(ram_n, 32'h4);
        chk(exp_faddr, 32'h0);
        chk({jtag_tile_allow, link_access_allow, jtag_otp_allow}, 32'h0);
        reg_read(4'h5, d);
        chk(d, 32'h0d15ab1e);
        otp_prog(11'h7ff, 32'h00001000);
        poll_sec(v | 32'h00001220);
        otp_prog(11'h7ff, 32'h00000400);
        otp_prog(11'h003, 32'h00000001);
        repeat (40) @(posedge sys_clk);
        reg_read(4'h0, d);
        chk(d, v | 32'h00001220);
        chk(u_blso_boot_loader.otp_mem[11'h003], 32'h0);
    endtask : security

    initial begin
        boot(2, 32'h0, 1'b0, 1'b1);
        boot(0, 32'h0, 1'b0, 1'b1);
        boot(1, 32'h0, 1'b1, 1'b1);
        boot(2, 32'h1, 1'b0, 1'b0);
        gap <= 4'h3;
        boot(3, 32'h0, 1'b0, 1'b1);
        security();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
